// [mrm_pkg.sv]
package mrm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MODE = 8'h0B;
    localparam logic [7:0] IDX_PULL = 8'h0C;
    localparam logic [7:0] IDX_RAM_POS = 8'h10;
    localparam logic [7:0] IDX_REG_POS = 8'h11;
    localparam logic [7:0] IDX_EE_POS = 8'h12;
    localparam logic [7:0] IDX_DEBUG = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    // Mode codes as {special_mode_not_bit, select B, select A}
    localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
    localparam logic [2:0] MODE_SPEC_NARROW = 3'h1;
    localparam logic [2:0] MODE_SPEC_PERIPH = 3'h2;
    localparam logic [2:0] MODE_SPEC_WIDE = 3'h3;
    localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
    localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
    localparam logic [2:0] MODE_RESERVED = 3'h6;
    localparam logic [2:0] MODE_NORM_WIDE = 3'h7;
    localparam logic [1:0] MODE_AB_PERIPH = 2'h2;
    // Field positions
    localparam int MODE_SPECIAL_MODE_NOT_BIT_BIT = 7;
    localparam int MODE_B_BIT = 6;
    localparam int MODE_A_BIT = 5;
    localparam int POS5_LSB = 3;
    localparam int POS4_LSB = 4;
    localparam int PULL_E_BIT = 0;
    localparam int PULL_AB_BIT = 1;
    localparam int DEBUG_EN_BIT = 0;
    // Reset values, EEPROM window offset and debug ROM page
    localparam logic [4:0] REG_POS_RESET = 5'h00;
    localparam logic [4:0] RAM_POS_RESET = 5'h01;
    localparam logic [3:0] EE_POS_RESET = 4'h0;
    localparam logic [11:0] EE_OFFSET_LOW = 12'hD00;
    localparam logic [7:0] DEBUG_ROM_PAGE = 8'hFF;
    // Cycles from reset release to the mode capture
    localparam logic [2:0] CAPTURE_CYCLES = 3'h5;
    // Port roles
    localparam logic [1:0] ROLE_GPIO = 2'h0;
    localparam logic [1:0] ROLE_ADDR_DATA = 2'h1;
    localparam logic [1:0] ROLE_ADDR_ONLY = 2'h2;
    localparam logic [1:0] ROLE_SLAVE_BUS = 2'h3;
    // Resource select positions
    localparam int SEL_ROM = 0;
    localparam int SEL_REG = 1;
    localparam int SEL_RAM = 2;
    localparam int SEL_EE = 3;
    localparam int SEL_PROG = 4;
    localparam int SEL_EXT = 5;
    typedef enum logic [1:0] {
        XFER_IDLE, XFER_HIGH, XFER_LOW, XFER_WIDE
    } mrm_xfer_type;
endpackage

// [mrm_top.sv]
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Latch debug and mode pins at reset release
// - Pullup debug pin, pulldown mode pins in reset
// - Decode seven modes from three pins; reserved code taken as peripheral
// - Wide: port A/B carry address and data
// - Narrow: A high address/data, B low address
// - Single chip: no bus, ports general I/O
// - Reset enables E pullups, disables A/B
// - Expanded (narrow and wide): port E bus-control outputs
// - Narrow transfers split high byte then low
// - Special single chip: debug active, no vector
// - Peripheral: CPU off, only reset changes it
// - Elsewhere debug activates only once enabled
// - Active debug ROM owns top page
// - Debug memory access uses idle bus cycles
// - Normal modes: position registers write once
// - New mapping acts two cycles after write
// - Decode precedence debug ROM down to external
// - Expanded: unclaimed addresses go external
// - Mode bit write rules and refused codes
// - Reset positions of registers, RAM, EEPROM
// - Register block on any 2-Kbyte boundary
module mrm_top #(
    parameter int ADDR_WIDTH = 10
) (
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_WIDTH-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic BACKGROUND_DEBUG_PIN_IN,
    input wire logic MODE_SELECT_B_PIN_IN,
    input wire logic MODE_SELECT_A_PIN_IN,
    output logic BACKGROUND_DEBUG_PULLUP_OUT,
    output logic MODE_SELECT_PULLDOWN_OUT,
    output logic MODE_VALID_OUT,
    output logic [2:0] MODE_OUT,
    output logic CPU_ACTIVE_OUT,
    output logic FETCH_RESET_VECTOR_OUT,
    output logic [1:0] PORT_A_ROLE_OUT,
    output logic [1:0] PORT_B_ROLE_OUT,
    output logic PORT_E_BUS_CTRL_OUT,
    output logic PORT_E_PULLUP_OUT,
    output logic PORT_AB_PULLUP_OUT,
    input wire logic DEBUG_ENABLE_CMD_IN,
    input wire logic DEBUG_ACTIVATE_CMD_IN,
    input wire logic ENTER_BACKGROUND_INSTRUCTION_IN,
    input wire logic DEBUG_EXIT_IN,
    output logic DEBUG_ACTIVE_OUT,
    input wire logic DEBUG_MEM_REQ_IN,
    input wire logic CPU_BUS_IDLE_IN,
    output logic DEBUG_MEM_GRANT_OUT,
    input wire logic EXT_REQ_IN,
    output logic EXT_READY_OUT,
    output logic EXT_HIGH_BYTE_OUT,
    output logic EXT_LOW_BYTE_OUT,
    output logic EXT_WORD_OUT,
    input wire logic CPU_ACCESS_IN,
    input wire logic [15:0] CPU_ADDR_IN,
    output logic SEL_DEBUG_ROM_OUT,
    output logic SEL_REG_BLOCK_OUT,
    output logic SEL_RAM_OUT,
    output logic SEL_EEPROM_OUT,
    output logic SEL_PROGRAM_OUT,
    output logic SEL_EXTERNAL_OUT
);
////////////////////////////////////////////////////////////////////////////
// Declarations
logic [2:0] pin_raw, sync1, sync2, sync3, pin_filt, cap_count, mode;
logic captured, capture_now, special_mode_not_bit, mode_select_b_pin, mode_select_a_pin, special_mode_not_bit_wr_seen, mode_wr_used;
logic special, periph, expanded, narrow, single_chip, pull_e, pull_ab;
logic [4:0] reg_pos, ram_pos, reg_pos_eff, ram_pos_eff, wd_reg_field;
logic [3:0] ee_pos, ee_pos_eff;
logic reg_pos_used, ram_pos_used, ee_pos_used, debug_enable, debug_active;
logic acc, hit, wr_mode, wr_reg_pos, ab_ok;
logic [7:0] idx;
logic [1:0] wd_ab;
logic [31:0] next_rdata;
logic [5:0] sel;
mrm_pkg::mrm_xfer_type xfer_state;
////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and reset-time capture
assign pin_raw = {BACKGROUND_DEBUG_PIN_IN, MODE_SELECT_B_PIN_IN,
                  MODE_SELECT_A_PIN_IN};
always_ff @(posedge REF_CLK_IN) begin
    {sync3, sync2, sync1} <= {sync2, sync1, pin_raw};
end
for (genvar i = 0; i < 3; i++) begin : g_filt
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pin_filt[i] <= mrm_pkg::MODE_NORM_SINGLE[i];
        end else if (sync2[i] == sync3[i]) begin
            pin_filt[i] <= sync3[i];
        end
    end
end
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        cap_count <= 3'h0;
        captured <= 1'b0;
    end else if (!captured) begin
        cap_count <= cap_count + 3'h1;
        captured <= capture_now;
    end
end
assign capture_now = !captured && (cap_count == mrm_pkg::CAPTURE_CYCLES);
assign BACKGROUND_DEBUG_PULLUP_OUT = !captured;
assign MODE_SELECT_PULLDOWN_OUT = !captured;
assign MODE_VALID_OUT = captured;
////////////////////////////////////////////////////////////////////////////
// APB decode
assign idx = PADDR_IN[9:2];
assign acc = PSEL_IN && PENABLE_IN;
assign hit = (PADDR_IN[1:0] == 2'h0) && (idx inside {mrm_pkg::IDX_MODE,
    mrm_pkg::IDX_PULL, mrm_pkg::IDX_RAM_POS, mrm_pkg::IDX_REG_POS,
    mrm_pkg::IDX_EE_POS, mrm_pkg::IDX_DEBUG, mrm_pkg::IDX_STATUS});
assign PREADY_OUT = 1'b1;
assign PSLVERR_OUT = acc && !hit;
assign wr_mode = acc && PWRITE_IN && hit && idx == mrm_pkg::IDX_MODE;
assign wr_reg_pos = acc && PWRITE_IN && hit &&
                    idx == mrm_pkg::IDX_REG_POS && (!special_mode_not_bit || !reg_pos_used);
assign wd_reg_field = PWDATA_IN[mrm_pkg::POS5_LSB +: 5];
assign wd_ab = {PWDATA_IN[mrm_pkg::MODE_B_BIT],
                PWDATA_IN[mrm_pkg::MODE_A_BIT]};
////////////////////////////////////////////////////////////////////////////
// Mode register
assign mode = {special_mode_not_bit, mode_select_b_pin, mode_select_a_pin};
assign special = !special_mode_not_bit;
assign periph = (mode == mrm_pkg::MODE_SPEC_PERIPH);
assign narrow = (mode == mrm_pkg::MODE_SPEC_NARROW) ||
                (mode == mrm_pkg::MODE_NORM_NARROW);
assign expanded = narrow || (mode == mrm_pkg::MODE_SPEC_WIDE) ||
                  (mode == mrm_pkg::MODE_NORM_WIDE);
assign single_chip = (mode == mrm_pkg::MODE_SPEC_SINGLE) ||
                     (mode == mrm_pkg::MODE_NORM_SINGLE);
assign ab_ok = (special || !mode_wr_used) && !periph &&
               (wd_ab != mrm_pkg::MODE_AB_PERIPH);
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        {special_mode_not_bit, mode_select_b_pin, mode_select_a_pin} <= mrm_pkg::MODE_NORM_SINGLE;
        special_mode_not_bit_wr_seen <= 1'b0;
        mode_wr_used <= 1'b0;
    end else if (capture_now) begin
        if (pin_filt == mrm_pkg::MODE_RESERVED) begin
            {special_mode_not_bit, mode_select_b_pin, mode_select_a_pin} <= mrm_pkg::MODE_SPEC_PERIPH;
        end else begin
            {special_mode_not_bit, mode_select_b_pin, mode_select_a_pin} <= pin_filt;
        end
    end else if (wr_mode) begin
        if (special && !periph) begin
            special_mode_not_bit_wr_seen <= 1'b1;
            if (special_mode_not_bit_wr_seen) begin
                special_mode_not_bit <= PWDATA_IN[mrm_pkg::MODE_SPECIAL_MODE_NOT_BIT_BIT];
            end
        end
        if (ab_ok) begin
            {mode_select_b_pin, mode_select_a_pin} <= wd_ab;
        end
        mode_wr_used <= mode_wr_used || special_mode_not_bit;
    end
end
assign MODE_OUT = mode;
////////////////////////////////////////////////////////////////////////////
// Position registers and their delayed effective copies
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        reg_pos <= mrm_pkg::REG_POS_RESET;
        ram_pos <= mrm_pkg::RAM_POS_RESET;
        ee_pos <= mrm_pkg::EE_POS_RESET;
        {reg_pos_used, ram_pos_used, ee_pos_used} <= 3'h0;
        reg_pos_eff <= mrm_pkg::REG_POS_RESET;
        ram_pos_eff <= mrm_pkg::RAM_POS_RESET;
        ee_pos_eff <= mrm_pkg::EE_POS_RESET;
    end else begin
        reg_pos_eff <= reg_pos;
        ram_pos_eff <= ram_pos;
        ee_pos_eff <= ee_pos;
        if (wr_reg_pos) begin
            reg_pos <= wd_reg_field;
            reg_pos_used <= 1'b1;
        end
        if (acc && PWRITE_IN && idx == mrm_pkg::IDX_RAM_POS && hit &&
            (special || !ram_pos_used)) begin
            ram_pos <= PWDATA_IN[mrm_pkg::POS5_LSB +: 5];
            ram_pos_used <= 1'b1;
        end
        if (acc && PWRITE_IN && idx == mrm_pkg::IDX_EE_POS && hit &&
            (special || !ee_pos_used)) begin
            ee_pos <= PWDATA_IN[mrm_pkg::POS4_LSB +: 4];
            ee_pos_used <= 1'b1;
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// Pullups and port roles
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        pull_e <= 1'b1;
        pull_ab <= 1'b0;
    end else if (acc && PWRITE_IN && hit && idx == mrm_pkg::IDX_PULL) begin
        pull_e <= PWDATA_IN[mrm_pkg::PULL_E_BIT];
        pull_ab <= PWDATA_IN[mrm_pkg::PULL_AB_BIT];
    end
end
assign PORT_E_PULLUP_OUT = pull_e;
assign PORT_AB_PULLUP_OUT = pull_ab;
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        PORT_A_ROLE_OUT <= mrm_pkg::ROLE_GPIO;
        PORT_B_ROLE_OUT <= mrm_pkg::ROLE_GPIO;
        PORT_E_BUS_CTRL_OUT <= 1'b0;
        CPU_ACTIVE_OUT <= 1'b0;
    end else begin
        CPU_ACTIVE_OUT <= captured && !periph;
        PORT_E_BUS_CTRL_OUT <= captured && expanded;
        PORT_A_ROLE_OUT <= (!captured || single_chip) ?
            mrm_pkg::ROLE_GPIO : periph ? mrm_pkg::ROLE_SLAVE_BUS :
            mrm_pkg::ROLE_ADDR_DATA;
        PORT_B_ROLE_OUT <= (!captured || single_chip) ?
            mrm_pkg::ROLE_GPIO : periph ? mrm_pkg::ROLE_SLAVE_BUS :
            narrow ? mrm_pkg::ROLE_ADDR_ONLY :
            mrm_pkg::ROLE_ADDR_DATA;
    end
end
////////////////////////////////////////////////////////////////////////////
// Background debug state
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        debug_enable <= 1'b0;
        debug_active <= 1'b0;
        FETCH_RESET_VECTOR_OUT <= 1'b0;
    end else begin
        FETCH_RESET_VECTOR_OUT <= capture_now && !periph_code(pin_filt) &&
            pin_filt != mrm_pkg::MODE_SPEC_SINGLE;
        if (capture_now && pin_filt == mrm_pkg::MODE_SPEC_SINGLE) begin
            debug_enable <= 1'b1;
            debug_active <= 1'b1;
        end else begin
            if (DEBUG_ENABLE_CMD_IN) begin
                debug_enable <= 1'b1;
            end else if (acc && PWRITE_IN && hit &&
                         idx == mrm_pkg::IDX_DEBUG) begin
                debug_enable <= PWDATA_IN[mrm_pkg::DEBUG_EN_BIT];
            end
            if (debug_enable && captured && !periph &&
                (DEBUG_ACTIVATE_CMD_IN ||
                 ENTER_BACKGROUND_INSTRUCTION_IN)) begin
                debug_active <= 1'b1;
            end else if (DEBUG_EXIT_IN) begin
                debug_active <= 1'b0;
            end
        end
    end
end
function automatic logic periph_code(input logic [2:0] code);
    periph_code = (code == mrm_pkg::MODE_SPEC_PERIPH) ||
                  (code == mrm_pkg::MODE_RESERVED);
endfunction
assign DEBUG_ACTIVE_OUT = debug_active;
assign DEBUG_MEM_GRANT_OUT = DEBUG_MEM_REQ_IN && CPU_BUS_IDLE_IN;
////////////////////////////////////////////////////////////////////////////
// External transfer sequencer
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        xfer_state <= mrm_pkg::XFER_IDLE;
    end else begin
        case (xfer_state)
            mrm_pkg::XFER_IDLE: begin
                if (EXT_REQ_IN && expanded && captured) begin
                    xfer_state <= narrow ? mrm_pkg::XFER_HIGH
                                         : mrm_pkg::XFER_WIDE;
                end
            end
            mrm_pkg::XFER_HIGH: xfer_state <= mrm_pkg::XFER_LOW;
            mrm_pkg::XFER_LOW: xfer_state <= mrm_pkg::XFER_IDLE;
            mrm_pkg::XFER_WIDE: xfer_state <= mrm_pkg::XFER_IDLE;
            default: xfer_state <= mrm_pkg::XFER_IDLE;
        endcase
    end
end
assign EXT_READY_OUT = (xfer_state == mrm_pkg::XFER_IDLE);
assign EXT_HIGH_BYTE_OUT = (xfer_state == mrm_pkg::XFER_HIGH);
assign EXT_LOW_BYTE_OUT = (xfer_state == mrm_pkg::XFER_LOW);
assign EXT_WORD_OUT = (xfer_state == mrm_pkg::XFER_WIDE);
////////////////////////////////////////////////////////////////////////////
// Address decoder
always_comb begin
    sel = 6'h00;
    if (!CPU_ACCESS_IN) begin
        sel = 6'h00;
    end else if (debug_active &&
                 CPU_ADDR_IN[15:8] == mrm_pkg::DEBUG_ROM_PAGE) begin
        sel[mrm_pkg::SEL_ROM] = 1'b1;
    end else if (CPU_ADDR_IN[15:11] == reg_pos_eff &&
                 CPU_ADDR_IN[10:9] == 2'h0) begin
        sel[mrm_pkg::SEL_REG] = 1'b1;
    end else if (CPU_ADDR_IN[15:11] == ram_pos_eff && !CPU_ADDR_IN[10]) begin
        sel[mrm_pkg::SEL_RAM] = 1'b1;
    end else if (CPU_ADDR_IN[15:12] == ee_pos_eff &&
                 CPU_ADDR_IN[11:0] >= mrm_pkg::EE_OFFSET_LOW) begin
        sel[mrm_pkg::SEL_EE] = 1'b1;
    end else if (single_chip && CPU_ADDR_IN[15]) begin
        sel[mrm_pkg::SEL_PROG] = 1'b1;
    end else if (expanded) begin
        sel[mrm_pkg::SEL_EXT] = 1'b1;
    end
end
assign SEL_DEBUG_ROM_OUT = sel[mrm_pkg::SEL_ROM];
assign SEL_REG_BLOCK_OUT = sel[mrm_pkg::SEL_REG];
assign SEL_RAM_OUT = sel[mrm_pkg::SEL_RAM];
assign SEL_EEPROM_OUT = sel[mrm_pkg::SEL_EE];
assign SEL_PROGRAM_OUT = sel[mrm_pkg::SEL_PROG];
assign SEL_EXTERNAL_OUT = sel[mrm_pkg::SEL_EXT];
////////////////////////////////////////////////////////////////////////////
// Read data
always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
        mrm_pkg::IDX_MODE: next_rdata[7:5] = mode;
        mrm_pkg::IDX_PULL: next_rdata[1:0] = {pull_ab, pull_e};
        mrm_pkg::IDX_RAM_POS: next_rdata[7:3] = ram_pos;
        mrm_pkg::IDX_REG_POS: next_rdata[7:3] = reg_pos;
        mrm_pkg::IDX_EE_POS: next_rdata[7:4] = ee_pos;
        mrm_pkg::IDX_DEBUG: next_rdata[0] = debug_enable;
        mrm_pkg::IDX_STATUS: next_rdata[3:0] = {captured, CPU_ACTIVE_OUT,
                                                debug_active, debug_enable};
        default: next_rdata = 32'h0000_0000;
    endcase
end
always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
        PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN) begin
        PRDATA_OUT <= hit ? next_rdata : 32'h0000_0000;
    end
end
////////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge REF_CLK_IN); endclocking
default disable iff (!RESET_N_IN);
mode_capture_a: assert property (capture_now && !periph_code(pin_filt) |=>
    mode == $past(pin_filt)) else $error("mode not latched");
pull_release_a: assert property (captured |->
    !BACKGROUND_DEBUG_PULLUP_OUT && !MODE_SELECT_PULLDOWN_OUT)
    else $error("pulls still on");
map_delay_a: assert property (wr_reg_pos |-> ##2
    reg_pos_eff == $past(wd_reg_field, 2))
    else $error("mapping delay wrong");
once_write_a: assert property (special_mode_not_bit && reg_pos_used && !capture_now |=>
    $stable(reg_pos)) else $error("second write taken");
periph_refuse_a: assert property (wr_mode && !periph && !capture_now |=>
    !periph) else $error("peripheral entered");
decode_onehot_a: assert property (CPU_ACCESS_IN && (expanded ||
    sel != 6'h00) |-> $onehot(sel)) else $error("select not one");
rom_gate_a: assert property (sel[mrm_pkg::SEL_ROM] |-> debug_active)
    else $error("rom without debug");
narrow_split_a: assert property (xfer_state == mrm_pkg::XFER_HIGH |=>
    xfer_state == mrm_pkg::XFER_LOW ##1 xfer_state == mrm_pkg::XFER_IDLE)
    else $error("split broken");
endmodule

// [mrm_ext_partner.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// External memory side: asks for one transfer, logs the strobes it sees
module mrm_ext_partner (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic ready_in,
    input wire logic high_in,
    input wire logic low_in,
    input wire logic word_in,
    output logic req_out,
    output logic [5:0] trace_out,
    output logic done_out
);
    initial begin
        req_out = 1'b0;
        trace_out = 6'h00;
        done_out = 1'b0;
    end
    // Request held until sampled with ready or for at most 8 cycles, then dropped at once
    always begin : run
        int n;
        @(posedge clk_in);
        if (go_in === 1'b1) begin
            done_out <= 1'b0;
            trace_out <= 6'h00;
            req_out <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_in);
                n++;
            end while (ready_in !== 1'b1 && n < 8);
            req_out <= 1'b0;
            // Strobe codes: 1 high byte, 2 low byte, 3 full word
            for (int i = 0; i < 3; i++) begin
                @(posedge clk_in);
                trace_out <= {trace_out[3:0], word_in ? 2'h3 : {low_in, high_in}};
            end
            done_out <= 1'b1;
        end
    end
endmodule

// [mrm_top_tb.sv]
`timescale 1ns/1ps
module mrm_top_tb;
    logic REF_CLK_IN = 1'b0, RESET_N_IN = 1'b0, PSEL_IN = 1'b0;
    logic PENABLE_IN = 1'b0, PWRITE_IN = 1'b0, PREADY_OUT, PSLVERR_OUT;
    logic [9:0] PADDR_IN = 10'h000;
    logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd, seed = 32'h62;
    logic BACKGROUND_DEBUG_PIN_IN = 1'b1, MODE_SELECT_B_PIN_IN = 1'b0;
    logic MODE_SELECT_A_PIN_IN = 1'b0, MODE_SELECT_PULLDOWN_OUT;
    logic BACKGROUND_DEBUG_PULLUP_OUT, MODE_VALID_OUT, CPU_ACTIVE_OUT;
    logic FETCH_RESET_VECTOR_OUT, PORT_E_BUS_CTRL_OUT, PORT_E_PULLUP_OUT;
    logic [2:0] MODE_OUT, em;
    logic [1:0] PORT_A_ROLE_OUT, PORT_B_ROLE_OUT, ra, rb;
    logic PORT_AB_PULLUP_OUT, DEBUG_ENABLE_CMD_IN = 1'b0, err, fetched;
    logic DEBUG_ACTIVATE_CMD_IN = 1'b0, ENTER_BACKGROUND_INSTRUCTION_IN = 1'b0;
    logic DEBUG_EXIT_IN = 1'b0, DEBUG_ACTIVE_OUT, DEBUG_MEM_REQ_IN = 1'b0;
    logic CPU_BUS_IDLE_IN = 1'b0, DEBUG_MEM_GRANT_OUT, EXT_REQ_IN;
    logic EXT_READY_OUT, EXT_HIGH_BYTE_OUT, EXT_LOW_BYTE_OUT, EXT_WORD_OUT;
    logic CPU_ACCESS_IN = 1'b1, SEL_DEBUG_ROM_OUT, SEL_REG_BLOCK_OUT;
    logic SEL_RAM_OUT, SEL_EEPROM_OUT, SEL_PROGRAM_OUT, SEL_EXTERNAL_OUT;
    logic go = 1'b0, ext_done;
    logic [15:0] CPU_ADDR_IN = 16'h0000;
    logic [5:0] trace;
    logic [15:0] corner [12] = '{16'h01FF, 16'h0200, 16'h0800, 16'h0BFF,
        16'h0C00, 16'h0CFF, 16'h0D00, 16'h0FFF, 16'h7FFF, 16'h8000,
        16'hFF00, 16'hFEFF};
    int fails = 0, compares = 0, cyc = 0;
////////////////////////////////////////////////////////////////////////////
    mrm_top #(.ADDR_WIDTH(10)) u_dut (.REF_CLK_IN, .RESET_N_IN, .PSEL_IN,
        .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
        .PREADY_OUT, .PSLVERR_OUT, .BACKGROUND_DEBUG_PIN_IN,
        .MODE_SELECT_B_PIN_IN, .MODE_SELECT_A_PIN_IN,
        .BACKGROUND_DEBUG_PULLUP_OUT, .MODE_SELECT_PULLDOWN_OUT,
        .MODE_VALID_OUT, .MODE_OUT, .CPU_ACTIVE_OUT, .FETCH_RESET_VECTOR_OUT,
        .PORT_A_ROLE_OUT, .PORT_B_ROLE_OUT, .PORT_E_BUS_CTRL_OUT,
        .PORT_E_PULLUP_OUT, .PORT_AB_PULLUP_OUT, .DEBUG_ENABLE_CMD_IN,
        .DEBUG_ACTIVATE_CMD_IN, .ENTER_BACKGROUND_INSTRUCTION_IN,
        .DEBUG_EXIT_IN, .DEBUG_ACTIVE_OUT, .DEBUG_MEM_REQ_IN,
        .CPU_BUS_IDLE_IN, .DEBUG_MEM_GRANT_OUT, .EXT_REQ_IN, .EXT_READY_OUT,
        .EXT_HIGH_BYTE_OUT, .EXT_LOW_BYTE_OUT, .EXT_WORD_OUT, .CPU_ACCESS_IN,
        .CPU_ADDR_IN, .SEL_DEBUG_ROM_OUT, .SEL_REG_BLOCK_OUT, .SEL_RAM_OUT,
        .SEL_EEPROM_OUT, .SEL_PROGRAM_OUT, .SEL_EXTERNAL_OUT);
    mrm_ext_partner u_mem (.clk_in(REF_CLK_IN), .go_in(go),
        .ready_in(EXT_READY_OUT), .high_in(EXT_HIGH_BYTE_OUT),
        .low_in(EXT_LOW_BYTE_OUT), .word_in(EXT_WORD_OUT),
        .req_out(EXT_REQ_IN), .trace_out(trace), .done_out(ext_done));
////////////////////////////////////////////////////////////////////////////
    always #2 REF_CLK_IN = ~REF_CLK_IN;
    always @(posedge REF_CLK_IN) begin
        cyc++;
        if (FETCH_RESET_VECTOR_OUT === 1'b1) fetched <= 1'b1;
        if (cyc == 5000) begin
            fails++;
            $display("mismatch run length expected 5000 seen more");
            complete_run();
        end
    end
////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected select {ext,prog,ee,ram,reg,rom} by precedence: one bit set, or none when nothing claims
    function automatic logic [5:0] exp_sel(input logic [2:0] m,
        input logic [15:0] a, input logic dbg, input logic [4:0] rp);
        if (dbg && a[15:8] == 8'hFF) return 6'h01;
        if (a[15:11] == rp && a[10:9] == 2'h0) return 6'h02;
        if (a[15:11] == 5'h01 && !a[10]) return 6'h04;
        if (a[15:12] == 4'h0 && a[11:0] >= 12'hD00) return 6'h08;
        if (m[1:0] == 2'h0 && a[15]) return 6'h10;
        if (m[0]) return 6'h20;
        return 6'h00;
    endfunction
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        @(posedge REF_CLK_IN);
        PSEL_IN <= 1'b1;
        PWRITE_IN <= w;
        PADDR_IN <= {idx, 2'h0};
        PWDATA_IN <= d;
        @(posedge REF_CLK_IN);
        PENABLE_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        while (PREADY_OUT !== 1'b1) @(posedge REF_CLK_IN);
        rd = PRDATA_OUT;
        err = PSLVERR_OUT;
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
    endtask
    task automatic dec(input logic [15:0] a, input logic [2:0] m,
        input logic dbg, input logic [4:0] rp);
        @(posedge REF_CLK_IN);
        CPU_ADDR_IN <= a;
        @(negedge REF_CLK_IN);
        chk("select", 16'(exp_sel(m, a, dbg, rp)), 16'({SEL_EXTERNAL_OUT, SEL_PROGRAM_OUT, SEL_EEPROM_OUT, SEL_RAM_OUT, SEL_REG_BLOCK_OUT, SEL_DEBUG_ROM_OUT}));
    endtask
    task automatic do_reset(input logic [2:0] m);
        BACKGROUND_DEBUG_PIN_IN <= m[2];
        MODE_SELECT_B_PIN_IN <= m[1];
        MODE_SELECT_A_PIN_IN <= m[0];
        RESET_N_IN <= 1'b0;
        repeat (10) @(posedge REF_CLK_IN);
        fetched <= 1'b0;
        chk("reset pulls", 16'h3, 16'({BACKGROUND_DEBUG_PULLUP_OUT, MODE_SELECT_PULLDOWN_OUT}));
        chk("port pullups", 16'h1, 16'({PORT_AB_PULLUP_OUT, PORT_E_PULLUP_OUT}));
        RESET_N_IN <= 1'b1;
        for (int i = 0; i < 20 && MODE_VALID_OUT !== 1'b1; i++) begin
            @(posedge REF_CLK_IN);
        end
        repeat (3) @(posedge REF_CLK_IN);
        chk("released pulls", 16'h0, 16'({BACKGROUND_DEBUG_PULLUP_OUT, MODE_SELECT_PULLDOWN_OUT}));
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int m = 0; m < 8; m++) begin
            em = (m == 6) ? 3'h2 : 3'(m);
            ra = (em[1:0] == 2'h0) ? 2'h0 : (em == 3'h2) ? 2'h3 : 2'h1;
            rb = (em[1:0] == 2'h1) ? 2'h2 : ra;
            do_reset(3'(m));
            chk("mode", 16'(em), 16'(MODE_OUT));
            chk("roles", 16'({ra, rb}), 16'({PORT_A_ROLE_OUT, PORT_B_ROLE_OUT}));
            chk("bus control", 16'(em[0]), 16'(PORT_E_BUS_CTRL_OUT));
            chk("cpu active", 16'(em != 3'h2), 16'(CPU_ACTIVE_OUT));
            chk("debug active", 16'(em == 3'h0), 16'(DEBUG_ACTIVE_OUT));
            chk("vector fetch", 16'(em[1:0] != 2'h2 && em != 3'h0), 16'(fetched));
            for (int k = 0; k < 24; k++) begin
                dec(k < 12 ? corner[k] : 16'(xs() >> 16), em, em == 3'h0, 5'h00);
            end
            @(posedge REF_CLK_IN);
            go <= 1'b1;
            @(posedge REF_CLK_IN);
            go <= 1'b0;
            @(posedge REF_CLK_IN);
            for (int i = 0; i < 30 && ext_done !== 1'b1; i++) begin
                @(posedge REF_CLK_IN);
            end
            chk("ext strobes", (em[1:0] == 2'h1) ? 16'h18 : (em[1:0] == 2'h3) ? 16'h30 : 16'h0, 16'(trace));
            $display("test mode %0d done", m);
        end
        do_reset(3'h4);
        apb(1'b0, mrm_pkg::IDX_PULL, 32'h0);
        chk("pull reg", 16'h1, 16'(rd[1:0]));
        @(posedge REF_CLK_IN);
        DEBUG_ACTIVATE_CMD_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        DEBUG_ACTIVATE_CMD_IN <= 1'b0;
        DEBUG_ENABLE_CMD_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        DEBUG_ENABLE_CMD_IN <= 1'b0;
        ENTER_BACKGROUND_INSTRUCTION_IN <= 1'b1;
        @(negedge REF_CLK_IN);
        chk("debug before enable", 16'h0, 16'(DEBUG_ACTIVE_OUT));
        @(posedge REF_CLK_IN);
        ENTER_BACKGROUND_INSTRUCTION_IN <= 1'b0;
        DEBUG_MEM_REQ_IN <= 1'b1;
        @(negedge REF_CLK_IN);
        chk("debug enabled", 16'h1, 16'(DEBUG_ACTIVE_OUT));
        chk("grant busy", 16'h0, 16'(DEBUG_MEM_GRANT_OUT));
        dec(16'hFF40, 3'h4, 1'b1, 5'h00);
        @(posedge REF_CLK_IN);
        CPU_BUS_IDLE_IN <= 1'b1;
        DEBUG_EXIT_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        DEBUG_EXIT_IN <= 1'b0;
        @(negedge REF_CLK_IN);
        chk("grant idle", 16'h1, 16'(DEBUG_MEM_GRANT_OUT));
        dec(16'hFF40, 3'h4, 1'b0, 5'h00);
        apb(1'b1, mrm_pkg::IDX_REG_POS, 32'h08);
        @(posedge REF_CLK_IN);
        dec(16'h0800, 3'h4, 1'b0, 5'h01);
        apb(1'b1, mrm_pkg::IDX_REG_POS, 32'h10);
        apb(1'b0, mrm_pkg::IDX_REG_POS, 32'h0);
        chk("normal second write", 16'h01, 16'(rd[7:3]));
        apb(1'b1, mrm_pkg::IDX_MODE, 32'hA0);
        apb(1'b1, mrm_pkg::IDX_MODE, 32'hE0);
        chk("normal mode write", 16'h5, 16'(MODE_OUT));
        apb(1'b0, 8'h3F, 32'h0);
        chk("unmapped", 16'h1, 16'(err));
        $display("test normal mode registers done");
        do_reset(3'h3);
        apb(1'b1, mrm_pkg::IDX_REG_POS, 32'h08);
        apb(1'b1, mrm_pkg::IDX_REG_POS, 32'h10);
        apb(1'b0, mrm_pkg::IDX_REG_POS, 32'h0);
        chk("special rewrite", 16'h02, 16'(rd[7:3]));
        apb(1'b1, mrm_pkg::IDX_MODE, 32'h40);
        apb(1'b0, mrm_pkg::IDX_MODE, 32'h0);
        chk("peripheral refused", 16'h3, 16'(rd[7:5]));
        $display("test special mode registers done");
        complete_run();
    end
endmodule
